// ==== cfq_pkg.sv ====
// Constants for the extended query table block: bus map, field values, variants.
package cfq_pkg;

  // ----------------------------------------------------------------
  // Bus map (byte addresses)
  // ----------------------------------------------------------------
  localparam int unsigned AXI_AW        = 12;
  localparam logic [11:0] QWIN_BASE     = 12'h000;  // Query word n at 4*n
  localparam logic [11:0] QWIN_LAST     = 12'h1fc;
  localparam logic [11:0] CTRL_OFS      = 12'h200;
  localparam logic [11:0] STAT_OFS      = 12'h204;
  localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
  localparam int unsigned CTRL_QEN_BIT  = 0;
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;

  // ----------------------------------------------------------------
  // Query word addresses
  // ----------------------------------------------------------------
  localparam logic [6:0] QA_EXT_PTR     = 7'h15;
  localparam logic [6:0] QA_EXT_PTR_HI  = 7'h16;
  localparam logic [6:0] QA_EXT_FIRST   = 7'h39;
  localparam logic [6:0] QA_EXT_LAST    = 7'h64;

  // ----------------------------------------------------------------
  // Fixed table values
  // ----------------------------------------------------------------
  localparam logic [7:0] QV_EXT_PTR     = 8'h39;
  localparam logic [7:0] QV_SIG_P       = 8'h50;
  localparam logic [7:0] QV_SIG_R       = 8'h52;
  localparam logic [7:0] QV_SIG_I       = 8'h49;
  localparam logic [7:0] QV_VER_MAJOR   = 8'h31;
  localparam logic [7:0] QV_VER_MINOR   = 8'h33;
  localparam logic [31:0] QV_FEATURES   = 32'h0000_03e6;
  localparam logic [7:0] QV_SUSPEND     = 8'h01;
  localparam logic [15:0] QV_BSR_MASK   = 16'h0003;
  localparam logic [7:0] QV_VCC_OPT     = 8'h18;
  localparam logic [7:0] QV_VPP_OPT     = 8'hc0;
  localparam logic [7:0] QV_PROT_CNT    = 8'h01;
  localparam logic [31:0] QV_PROT_DESC  = 32'h0303_0080;
  localparam logic [7:0] QV_PAGE_N      = 8'h03;
  localparam logic [7:0] QV_SYNC_CNT    = 8'h03;
  localparam logic [7:0] QV_SYNC_1      = 8'h01;
  localparam logic [7:0] QV_SYNC_2      = 8'h02;
  localparam logic [7:0] QV_SYNC_3      = 8'h07;
  localparam logic [7:0] QV_PREG_CNT    = 8'h02;
  localparam logic [15:0] QV_BOT_PCNT   = 16'h0001;
  localparam logic [7:0] QV_RD_CONC     = 8'h01;
  localparam logic [7:0] QV_PG_CONC     = 8'h00;
  localparam logic [7:0] QV_ER_CONC     = 8'h00;
  localparam logic [7:0] QV_BOT_EBR_CNT = 8'h02;
  localparam logic [31:0] QV_BOT_EB1    = 32'h0020_0007;
  localparam logic [31:0] QV_TOP_EB1    = 32'h0100_0007;
  localparam logic [15:0] QV_ERASE_KCYC = 16'h0064;
  localparam logic [7:0] QV_CELL        = 8'h01;
  localparam logic [7:0] QV_BOT_CAP     = 8'h02;
  localparam logic [7:0] QV_TOP_CAP     = 8'h03;
  localparam logic [31:0] QV_BOT_EB2    = 32'h0100_0006;
  // Top device: first fields of the second partition region follow at 60h
  localparam logic [15:0] QV_TOP_R2_PCNT = 16'h0001;
  localparam logic [7:0] QV_TOP_R2_RD   = 8'h01;
  localparam logic [7:0] QV_TOP_R2_PG   = 8'h00;
  localparam logic [7:0] QV_TOP_R2_ER   = 8'h00;

  // Top device partition count and erase block count, by density 16/32/64/128
  localparam logic [7:0] QV_TOP_PCNT [4] = '{8'h03, 8'h07, 8'h0f, 8'h1f};

endpackage : cfq_pkg

// ==== cfq_query_table.sv ====
// Extended query table readable over an AXI4-Lite slave port.
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Function
// (R01) Offsets 0..2 at 39h..3Bh read ASCII 50, 52, 49.
// (R02) Major version 31 then minor version 33 follow.
// (R03) Feature field reads E6, 03, 00, 00, low byte first.
// (R04) Feature bits 10..31 read zero; no appended feature field.
// (R05) After-suspend byte reads 01: program allowed in erase suspend.
// (R06) Block status mask reads 03 then 00.
// (R07) Optimum logic supply reads 18, programming supply reads C0.
// (R08) Protection field count reads 01.
// (R09) Protection descriptor reads 80, 00, 03, 03.
// (R10) Page read byte reads 03, eight-byte pages.
// (R11) Synchronous configuration entry count reads 03.
// (R12) Synchronous entries read 01, 02, 07.
// (R13) Host may copy a burst code into its read configuration register.
// (R14) Partition region count byte reports regions present.
// (R15) Identical partition count at 52h/53h, low byte first.
// (R16) Three concurrency bytes: programs in low nibble, erases in high.
// (R17) Erase block region count per partition region.
// (R18) Erase region descriptor: y in bits 0..15, z in 16..31.
// (R19) Minimum erase cycles field in thousands, two bytes.
// (R20) Cell byte: bits per cell in bits 0..3, upper bits reserved.
// (R21) Capability byte: page read, sync read, sync write in bits 0..2.
// (R22) Bottom device alone has second erase region at 60h..64h.
// (R23) Basic structure offset 15h reads the table base 39h.
// (R24) Multi-byte fields place least significant byte lowest.
// (R25) Upper data byte of every query word reads 00h.
// (R26) Content fixed and read-only; unlisted addresses read zero.
module cfq_query_table
  import cfq_pkg::*;
#(
  parameter logic       BOTTOM_PARAM = 1'b1,   // 1 bottom, 0 top parameter device
  parameter logic [1:0] DENSITY_SEL  = 2'd1    // 0..3 for 16/32/64/128 Mbit
) (
  // Clock and reset
  input  wire logic                ref_clk_i,
  input  wire logic                rst_b_i,
  // AXI4-Lite write address
  input  wire logic                s_axi_awvalid_i,
  output logic                     s_axi_awready_o,
  input  wire logic [AXI_AW-1:0]   s_axi_awaddr_i,
  input  wire logic [2:0]          s_axi_awprot_i,
  // AXI4-Lite write data
  input  wire logic                s_axi_wvalid_i,
  output logic                     s_axi_wready_o,
  input  wire logic [31:0]         s_axi_wdata_i,
  input  wire logic [3:0]          s_axi_wstrb_i,
  // AXI4-Lite write response
  output logic                     s_axi_bvalid_o,
  input  wire logic                s_axi_bready_i,
  output logic [1:0]               s_axi_bresp_o,
  // AXI4-Lite read address
  input  wire logic                s_axi_arvalid_i,
  output logic                     s_axi_arready_o,
  input  wire logic [AXI_AW-1:0]   s_axi_araddr_i,
  input  wire logic [2:0]          s_axi_arprot_i,
  // AXI4-Lite read data
  output logic                     s_axi_rvalid_o,
  input  wire logic                s_axi_rready_i,
  output logic [31:0]              s_axi_rdata_o,
  output logic [1:0]               s_axi_rresp_o
);

  // ----------------------------------------------------------------
  // Table content
  // ----------------------------------------------------------------

  // Word map of the window, bottom device
  // (top differs at 52h, 57h, 5Ah, 5Bh, 5Fh..61h, 63h, 64h)
  //
  //   15h  table base low
  //   16h  table base high
  //   39h  signature 0
  //   3Ah  signature 1
  //   3Bh  signature 2
  //   3Ch  major version
  //   3Dh  minor version
  //   3Eh  features 7:0
  //   3Fh  features 15:8
  //   40h  features 23:16
  //   41h  features 31:24
  //   42h  after suspend
  //   43h  status mask lo
  //   44h  status mask hi
  //   45h  logic supply
  //   46h  prog supply
  //   47h  prot count
  //   48h  lock addr lo
  //   49h  lock addr hi
  //   4Ah  factory n
  //   4Bh  user n
  //   4Ch  page n
  //   4Dh  burst count
  //   4Eh  burst 1
  //   4Fh  burst 2
  //   50h  burst 3
  //   51h  part regions
  //   52h  parts lo
  //   53h  parts hi
  //   54h  conc read
  //   55h  conc program
  //   56h  conc erase
  //   57h  erase regions
  //   58h  reg1 y lo
  //   59h  reg1 y hi
  //   5Ah  reg1 z lo
  //   5Bh  reg1 z hi
  //   5Ch  kcycles lo
  //   5Dh  kcycles hi
  //   5Eh  cell byte
  //   5Fh  capability
  //   60h  reg2 y lo
  //   61h  reg2 y hi
  //   62h  reg2 z lo
  //   63h  reg2 z hi
  //   64h  reg2 kcyc lo
  //
  // Top device: 60h..64h open the
  // second partition region.
  // Top part counts by density:
  // 03h, 07h, 0Fh, 1Fh
  //
  // All other words read 00h.
  //

  // Byte k of a little-endian multi-byte field
  function automatic logic [7:0] field_byte(input logic [31:0] val, input logic [1:0] k);
    field_byte = val[8*k +: 8];  // R24
  endfunction : field_byte

  // Query byte at a word address for the configured variant
  function automatic logic [7:0] query_byte(input logic [6:0] a, input logic bot,
                                            input logic [1:0] dens);
    logic [7:0] tcnt;
    tcnt = QV_TOP_PCNT[dens];
    query_byte = 8'h00;  // R26
    case (a)
      QA_EXT_PTR:    query_byte = QV_EXT_PTR;  // R23
      QA_EXT_PTR_HI: query_byte = 8'h00;
      7'h39: query_byte = QV_SIG_P;  // R01
      7'h3a: query_byte = QV_SIG_R;  // R01
      7'h3b: query_byte = QV_SIG_I;  // R01
      7'h3c: query_byte = QV_VER_MAJOR;  // R02
      7'h3d: query_byte = QV_VER_MINOR;  // R02
      7'h3e, 7'h3f, 7'h40, 7'h41: begin
        query_byte = field_byte(QV_FEATURES, 2'(a - 7'h3e));  // R03 R04
      end
      7'h42: query_byte = QV_SUSPEND;  // R05
      7'h43, 7'h44: begin
        query_byte = field_byte({16'h0000, QV_BSR_MASK}, 2'(a - 7'h43));  // R06
      end
      7'h45: query_byte = QV_VCC_OPT;  // R07
      7'h46: query_byte = QV_VPP_OPT;  // R07
      7'h47: query_byte = QV_PROT_CNT;  // R08
      7'h48, 7'h49, 7'h4a, 7'h4b: begin
        query_byte = field_byte(QV_PROT_DESC, 2'(a - 7'h48));  // R09
      end
      7'h4c: query_byte = QV_PAGE_N;  // R10
      7'h4d: query_byte = QV_SYNC_CNT;  // R11
      7'h4e: query_byte = QV_SYNC_1;  // R12
      7'h4f: query_byte = QV_SYNC_2;  // R12
      7'h50: query_byte = QV_SYNC_3;  // R12
      7'h51: query_byte = QV_PREG_CNT;  // R14
      7'h52, 7'h53: begin
        query_byte = bot ? field_byte({16'h0000, QV_BOT_PCNT}, 2'(a - 7'h52))
                         : field_byte({24'h000000, tcnt}, 2'(a - 7'h52));  // R15
      end
      7'h54: query_byte = QV_RD_CONC;  // R16
      7'h55: query_byte = QV_PG_CONC;  // R16
      7'h56: query_byte = QV_ER_CONC;  // R16
      7'h57: query_byte = bot ? QV_BOT_EBR_CNT : tcnt;  // R17
      7'h58, 7'h59, 7'h5a, 7'h5b: begin
        query_byte = field_byte(bot ? QV_BOT_EB1 : QV_TOP_EB1, 2'(a - 7'h58));  // R18
      end
      7'h5c, 7'h5d: begin
        query_byte = field_byte({16'h0000, QV_ERASE_KCYC}, 2'(a - 7'h5c));  // R19
      end
      7'h5e: query_byte = QV_CELL;  // R20
      7'h5f: query_byte = bot ? QV_BOT_CAP : QV_TOP_CAP;  // R21
      7'h60, 7'h61, 7'h62, 7'h63: begin
        if (bot) begin
          query_byte = field_byte(QV_BOT_EB2, 2'(a - 7'h60));  // R22
        end else begin
          query_byte = field_byte({QV_TOP_R2_ER, QV_TOP_R2_PG, QV_TOP_R2_RD,
                                   8'h00} | {16'h0000, QV_TOP_R2_PCNT},
                                  2'(a - 7'h60));
        end
      end
      QA_EXT_LAST: query_byte = bot ? field_byte({16'h0000, QV_ERASE_KCYC}, 2'd0)
                                    : 8'h00;  // R22
      default: query_byte = 8'h00;  // R26
    endcase
  endfunction : query_byte

  // Word in the query window: upper byte always zero
  function automatic logic [31:0] query_word(input logic [6:0] a, input logic bot,
                                             input logic [1:0] dens);
    query_word = {24'h000000, query_byte(a, bot, dens)};  // R25
  endfunction : query_word

  // ----------------------------------------------------------------
  // Control and status state
  // ----------------------------------------------------------------
  logic        query_en_reg;
  logic [6:0]  last_qaddr_reg;
  logic [15:0] qread_cnt_reg;

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  logic              aw_held_reg;
  logic [AXI_AW-1:0] awaddr_reg;
  logic              w_held_reg;
  logic [31:0]       wdata_reg;
  logic [3:0]        wstrb_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              wr_fire;

  // Write path timing
  //
  //   AW and W in any order.
  //   B rises a cycle after both
  //   are held, stands to bready.
  //   No ready while B pends, so
  //   one write is in flight.
  //

  // Address and data are taken in either order, one write at a time
  assign s_axi_awready_o = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready_o  = !w_held_reg && !bvalid_reg;
  assign wr_fire         = aw_held_reg && w_held_reg && !bvalid_reg;

  // Capture write address
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      aw_held_reg <= 1'b0;
      awaddr_reg  <= '0;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_held_reg <= 1'b1;
      awaddr_reg  <= s_axi_awaddr_i;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  // Capture write data
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      w_held_reg <= 1'b0;
      wdata_reg  <= '0;
      wstrb_reg  <= '0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_held_reg <= 1'b1;
      wdata_reg  <= s_axi_wdata_i;
      wstrb_reg  <= s_axi_wstrb_i;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  // Write response: only the control word accepts writes
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= ({awaddr_reg[AXI_AW-1:2], 2'b00} == CTRL_OFS) ? RESP_OKAY
                                                                   : RESP_SLVERR;  // R26
    end else if (s_axi_bready_i) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o  = bresp_reg;

  // Control register: query mode enable
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      query_en_reg <= CTRL_RST[CTRL_QEN_BIT];
    end else if (wr_fire && ({awaddr_reg[AXI_AW-1:2], 2'b00} == CTRL_OFS)
                 && wstrb_reg[0]) begin
      query_en_reg <= wdata_reg[CTRL_QEN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  logic              rvalid_reg;
  logic [31:0]       rdata_reg;
  logic [1:0]        rresp_reg;
  logic [AXI_AW-1:0] ra_word;
  logic              ra_in_win;
  logic [31:0]       rd_next;
  logic [1:0]        rresp_next;

  assign s_axi_arready_o = !rvalid_reg;
  assign ra_word         = {s_axi_araddr_i[AXI_AW-1:2], 2'b00};
  assign ra_in_win       = (ra_word >= QWIN_BASE) && (ra_word <= QWIN_LAST);

  // Read decode: window, control, status, else error with zero data
  always_comb begin
    rd_next    = 32'h0000_0000;
    rresp_next = RESP_OKAY;
    if (ra_in_win) begin
      if (query_en_reg) begin
        rd_next = query_word(ra_word[8:2], BOTTOM_PARAM, DENSITY_SEL);  // R26
      end
    end else if (ra_word == CTRL_OFS) begin
      rd_next[CTRL_QEN_BIT] = query_en_reg;
    end else if (ra_word == STAT_OFS) begin
      rd_next = {qread_cnt_reg, 1'b0, last_qaddr_reg, 4'h0, DENSITY_SEL,
                 BOTTOM_PARAM, query_en_reg};
    end else begin
      rresp_next = RESP_SLVERR;
    end
  end

  // Notes for software
  //
  //   Query mode is off after reset;
  //   the window reads zero until
  //   CTRL bit 0 is set.
  //   Window reads never fail.
  //   Writes off CTRL get SLVERR
  //   and change nothing.
  //   Address bits 1:0 are ignored.
  //   STATUS 31:16 counts window
  //   reads made in query mode;
  //   the count wraps.
  //

  // Read path timing
  //
  //   Data stand a cycle after
  //   the address, until rready.
  //   arready is low meanwhile.
  //

  // Read data register, answered one cycle after the address is taken
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_next;
      rresp_reg  <= rresp_next;
    end else if (s_axi_rready_i) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Query read tracking for status
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      last_qaddr_reg <= '0;
      qread_cnt_reg  <= '0;
    end else if (s_axi_arvalid_i && s_axi_arready_o && ra_in_win && query_en_reg) begin
      last_qaddr_reg <= ra_word[8:2];
      qread_cnt_reg  <= qread_cnt_reg + 16'h0001;
    end
  end

  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rdata_o  = rdata_reg;
  assign s_axi_rresp_o  = rresp_reg;

endmodule : cfq_query_table

`default_nettype wire

// ==== cfq_query_table_monitor.sv ====
// Property checker for the query table slave port.
`timescale 1ns/1ps
`default_nettype none
module cfq_query_table_monitor
  import cfq_pkg::*;
(
  // Clock and reset
  input wire logic              ref_clk_i,
  input wire logic              rst_b_i,
  // Write side
  input wire logic              s_axi_awvalid_i,
  input wire logic              s_axi_awready_o,
  input wire logic [AXI_AW-1:0] s_axi_awaddr_i,
  input wire logic              s_axi_bvalid_o,
  input wire logic              s_axi_bready_i,
  input wire logic [1:0]        s_axi_bresp_o,
  // Read side
  input wire logic              s_axi_arvalid_i,
  input wire logic              s_axi_arready_o,
  input wire logic [AXI_AW-1:0] s_axi_araddr_i,
  input wire logic              s_axi_rvalid_o,
  input wire logic              s_axi_rready_i,
  input wire logic [31:0]       s_axi_rdata_o,
  input wire logic [1:0]        s_axi_rresp_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  // ----------------------------------------------------------------
  // Addresses of the requests in flight
  // ----------------------------------------------------------------
  logic [AXI_AW-1:0] ar_reg;
  logic [AXI_AW-1:0] aw_reg;
  logic [6:0]        wd;
  logic              win;
  // Capture read address when taken
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) ar_reg <= '0;
    else if (s_axi_arvalid_i && s_axi_arready_o) ar_reg <= s_axi_araddr_i;
  end
  // Capture write address when taken
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) aw_reg <= '0;
    else if (s_axi_awvalid_i && s_axi_awready_o) aw_reg <= s_axi_awaddr_i;
  end
  // Query word of the pending read
  assign wd  = ar_reg[8:2];
  assign win = (ar_reg <= QWIN_LAST);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  rd_latency_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer not one cycle after address");
  rd_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o)) else $error("read dropped");
  ar_refuse_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read address taken while busy");
  upper_zero_a: assert property (s_axi_rvalid_o && win |->
    s_axi_rdata_o[31:8] == 24'h0) else $error("upper query byte not zero");
  sig_byte_a: assert property (s_axi_rvalid_o && win && wd == 7'h39 |->
    s_axi_rdata_o inside {32'h0, 32'h50}) else $error("signature byte wrong");
  feat_byte_a: assert property (s_axi_rvalid_o && win && wd == 7'h3e |->
    s_axi_rdata_o inside {32'h0, 32'he6}) else $error("feature byte wrong");
  unlisted_zero_a: assert property (s_axi_rvalid_o && win && (wd > 7'h64 || wd < 7'h15) |->
    s_axi_rdata_o == 32'h0) else $error("unlisted word not zero");
  unmapped_rd_a: assert property (s_axi_rvalid_o && ar_reg[11:2] > STAT_OFS[11:2] |->
    s_axi_rresp_o == RESP_SLVERR && s_axi_rdata_o == 32'h0) else $error("unmapped read");
  ro_window_a: assert property (s_axi_bvalid_o && aw_reg <= QWIN_LAST |->
    s_axi_bresp_o == RESP_SLVERR) else $error("window write accepted");
  b_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write response dropped");
  // Main scenarios seen
  cover property (s_axi_rvalid_o && s_axi_rready_i && win && s_axi_rdata_o != 32'h0);
  cover property (s_axi_bvalid_o && s_axi_bready_i && s_axi_bresp_o == RESP_SLVERR);
  cover property (s_axi_bvalid_o && s_axi_bready_i && s_axi_bresp_o == RESP_OKAY);
endmodule : cfq_query_table_monitor
`default_nettype wire

// ==== cfq_host_model.sv ====
// Host bus master model that reads the query table over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module cfq_host_model
  import cfq_pkg::*;
(
  // Clock and slave answers
  input wire logic              clk_i,
  input wire logic              awready_i,
  input wire logic              wready_i,
  input wire logic              bvalid_i,
  input wire logic              arready_i,
  input wire logic              rvalid_i,
  // Requests
  output var logic              awvalid_o,
  output var logic              wvalid_o,
  output var logic              bready_o,
  output var logic              arvalid_o,
  output var logic              rready_o,
  output var logic [AXI_AW-1:0] awaddr_o,
  output var logic [AXI_AW-1:0] araddr_o,
  output var logic [31:0]       wdata_o,
  output var logic [3:0]        wstrb_o
);
  // Idle bus at time zero
  initial begin
    {awvalid_o, wvalid_o, bready_o, arvalid_o, rready_o} = 5'h0;
    {awaddr_o, araddr_o, wdata_o, wstrb_o} = '0;
  end
  // Random stall before accepting an answer
  task automatic pause();
    repeat ($urandom_range(0, 2)) @(posedge clk_i);
  endtask : pause
  // Write: both channels offered together, each released when taken
  task automatic wr(input logic [AXI_AW-1:0] a, input logic [31:0] d, input logic [3:0] s);
    logic pa;
    logic pw;
    pa = 1'b1;
    pw = 1'b1;
    awaddr_o <= a; wdata_o <= d; wstrb_o <= s; awvalid_o <= 1'b1; wvalid_o <= 1'b1;
    do begin
      @(posedge clk_i);
      if (pa && awready_i) begin
        pa = 1'b0; awvalid_o <= 1'b0; awaddr_o <= ~a;
      end
      if (pw && wready_i) begin
        pw = 1'b0; wvalid_o <= 1'b0; wdata_o <= ~d;
      end
    end while (pa || pw);
    pause();
    bready_o <= 1'b1;
    do @(posedge clk_i); while (!bvalid_i);
    bready_o <= 1'b0;
  endtask : wr
  // Read: address held until taken, data accepted after a stall
  task automatic rd(input logic [AXI_AW-1:0] a);
    araddr_o <= a; arvalid_o <= 1'b1;
    do @(posedge clk_i); while (!arready_i);
    arvalid_o <= 1'b0; araddr_o <= ~a;
    pause();
    rready_o <= 1'b1;
    do @(posedge clk_i); while (!rvalid_i);
    rready_o <= 1'b0;
  endtask : rd
endmodule : cfq_host_model
`default_nettype wire

// ==== tb_cfi_extended_query_table.sv ====
// Self-checking bench for the extended query table block.
`timescale 1ns/1ps
`default_nettype none
module tb_cfi_extended_query_table
  import cfq_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic awv, awr, wv, wr_, bv, br, arv, arr, rv, rr;
  logic [AXI_AW-1:0] awa, ara;
  logic [31:0] wd, rd;
  logic [3:0] ws;
  logic [1:0] bresp, rresp;
  logic [65:0] rd_q[$];
  logic [1:0] wr_q[$];
  logic [6:0] w;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  // Query words 39h..64h, first word in the top byte
  localparam logic [351:0] TBL = {176'h505249_3133_e6030000_01_0300_18c0_01_80000303_03_03_01,
    176'h0207_02_0100_010000_02_07002000_6400_01_02_06000001_64};
  always #20 ref_clk_i = ~ref_clk_i;
  cfq_query_table i_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_awaddr_i(awa), .s_axi_awprot_i(3'h0),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(br), .s_axi_bresp_o(bresp),
    .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_araddr_i(ara), .s_axi_arprot_i(3'h0),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rr), .s_axi_rdata_o(rd), .s_axi_rresp_o(rresp));
  cfq_host_model i_host (.clk_i(ref_clk_i), .awready_i(awr), .wready_i(wr_), .bvalid_i(bv),
    .arready_i(arr), .rvalid_i(rv), .awvalid_o(awv), .wvalid_o(wv), .bready_o(br),
    .arvalid_o(arv), .rready_o(rr), .awaddr_o(awa), .araddr_o(ara), .wdata_o(wd), .wstrb_o(ws));
  // Expected content of one query word with query mode on
  function automatic logic [31:0] qword(input logic [6:0] n);
    if (n >= 7'h39 && n <= 7'h64) return {24'h0, TBL[8*(7'h64 - n) +: 8]};
    return (n == 7'h15) ? 32'h39 : 32'h0;
  endfunction : qword
  // Note an expected read result, then issue the read
  task automatic exp_rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r,
                        input logic [31:0] m);
    rd_q.push_back({m, r, d});
    i_host.rd(a);
  endtask : exp_rd
  // Note an expected write response, then issue the write
  task automatic exp_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] r);
    wr_q.push_back(r);
    i_host.wr(a, d, s);
  endtask : exp_wr
  // Compare one read result under its mask
  task automatic check_rd(input logic [31:0] d, input logic [1:0] r);
    logic [65:0] e;
    e = rd_q.pop_front();
    samples_checked++;
    if (((d & e[65:34]) !== e[31:0]) || (r !== e[33:32])) begin
      err_total++;
      $display("mismatch at %0t: read %h/%h expected %h/%h", $time, d, r, e[31:0], e[33:32]);
    end
  endtask : check_rd
  // Compare one write response
  task automatic check_wr(input logic [1:0] r);
    logic [1:0] e;
    e = wr_q.pop_front();
    samples_checked++;
    if (r !== e) begin
      err_total++;
      $display("mismatch at %0t: bresp %h expected %h", $time, r, e);
    end
  endtask : check_wr
  // Verdict and end of run
  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  // Result watcher: takes the oldest note at each handshake
  always @(posedge ref_clk_i) begin
    if (rv && rr) check_rd(rd, rresp);
    if (bv && br) check_wr(bresp);
  end
  // Hang guard
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      summarize();
    end
  end
  // Main sequence
  initial begin
    void'($urandom(67));
    repeat (6) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    exp_rd(12'h0e4, 32'h0, RESP_OKAY, '1);
    exp_wr(CTRL_OFS, 32'h1, 4'he, RESP_OKAY);
    exp_rd(12'h0e4, 32'h0, RESP_OKAY, '1);
    exp_wr(CTRL_OFS, 32'h1, 4'h1, RESP_OKAY);
    exp_rd(CTRL_OFS, 32'h1, RESP_OKAY, 32'h1);
    exp_rd(STAT_OFS, 32'h7, RESP_OKAY, 32'hf);
    exp_rd(12'h138, 32'h1, RESP_OKAY, 32'h7);
    for (int i = 8'h15; i <= 8'h7f; i++) begin
      w = 7'(i);
      exp_rd({3'h0, w, 2'($urandom_range(0, 3))}, qword(w), RESP_OKAY, '1);
    end
    exp_wr(12'h0e4, $urandom, 4'hf, RESP_SLVERR);
    exp_rd(12'h0e4, 32'h50, RESP_OKAY, '1);
    exp_rd(12'h300, 32'h0, RESP_SLVERR, '1);
    exp_wr(12'h300, $urandom, 4'hf, RESP_SLVERR);
    repeat (40) begin
      w = 7'($urandom_range(0, 127));
      exp_rd({3'h0, w, 2'h0}, qword(w), RESP_OKAY, '1);
    end
    exp_wr(CTRL_OFS, 32'h0, 4'h1, RESP_OKAY);
    exp_rd(12'h0e4, 32'h0, RESP_OKAY, '1);
    @(posedge ref_clk_i);
    summarize();
  end
endmodule : tb_cfi_extended_query_table
bind cfq_query_table cfq_query_table_monitor i_mon (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
  .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
  .s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_bresp_o(s_axi_bresp_o),
  .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
  .s_axi_araddr_i(s_axi_araddr_i), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rready_i(s_axi_rready_i), .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o));
`default_nettype wire
